/* File: include/tma_consts.svh */
// Purpose: offsets, field positions and counts for the timer block
// Assumes: byte addresses on an 8-bit Wishbone address
// Notes:   definitions only
`ifndef TMA_CONSTS_SVH
`define TMA_CONSTS_SVH

`define TMA_NCH        5
`define TMA_CH_STRIDE  8'h08
`define TMA_MODE_OFS   8'h00
`define TMA_TMR_OFS    8'h04
`define TMA_START_OFS  8'h28
`define TMA_UPDN_OFS   8'h2C
`define TMA_OSTART_OFS 8'h30
`define TMA_TRGSEL_OFS 8'h34

`define TMA_F_POE      2
`define TMA_F_FREE     3
`define TMA_F_DIRSRC   4
`define TMA_F_SRC_HI   7
`define TMA_F_SRC_LO   6

`define TMA_CNT_MAX    16'hFFFF
`define TMA_CNT_ZERO   16'h0000
`define TMA_INDET_VAL  16'h0000
`define TMA_PRE_MASK8  5'h07
`define TMA_PRE_TOP    5'h1F

`endif

/* File: include/tma_pkg.sv */
// Purpose: shared types of the timer block
// Assumes: nothing
// Notes:   mode codes sit in mode register bits 1..0
package tma_pkg;
	typedef enum logic [1:0] {
		TMA_TIMER   = 2'h0,
		TMA_EVENT   = 2'h1,
		TMA_ONESHOT = 2'h2,
		TMA_PWM     = 2'h3
	} tma_mode_t;

	typedef enum logic [1:0] {
		TMA_SRC_DIV1  = 2'h0,
		TMA_SRC_DIV8  = 2'h1,
		TMA_SRC_DIV32 = 2'h2,
		TMA_SRC_SUB32 = 2'h3
	} tma_src_t;
endpackage

/* File: logic/tma_timer.sv */
// Purpose: five-channel 16-bit multimode timer with Wishbone registers
// Assumes: classic Wishbone slave, one clock, synchronous reset
// Notes:   pulse pins exist on channels 2 and 3 only
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "tma_consts.svh"

module tma_timer
	import tma_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        subclk_i,
	input  wire logic        tb2_ovf_i,
	input  wire logic [4:0]  trig_i,
	input  wire logic [1:0]  pulse_i,
	output logic      [1:0]  pulse_o,
	output logic      [1:0]  pulse_oe_o,
	output logic      [4:0]  irq_o
);

	// ********************************************************
	// helpers
	// ********************************************************

	// address of a per-channel register
	function automatic logic chan_hit(input logic [7:0] a,
		input logic [7:0] ofs, input logic [2:0] ch);
		logic [7:0] base;
		base = 8'(ofs + 8'({5'h00, ch} * `TMA_CH_STRIDE));
		return a[7:2] == base[7:2];
	endfunction

	// byte-lane merge of a write into the low 16 bits
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] d, input logic [1:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// ********************************************************
	// wishbone slave
	// ********************************************************

	logic        ack_ff;
	logic [31:0] dat_ff;
	logic        req;
	logic        wr_en;
	logic [31:0] nxt_dat;

	assign req   = cyc_i && stb_i;
	// writes land on the edge that sees ack high, as the master expects
	assign wr_en = req && we_i && ack_ff;
	assign ack_o = ack_ff;
	assign dat_o = dat_ff;

	// one wait state, ack drops the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req && !ack_ff;
		end
	end

	// ********************************************************
	// global registers
	// ********************************************************

	logic [4:0] start_ff;
	logic [4:0] updn_ff;
	logic [4:0] trgsel_ff;
	logic [4:0] ost_ff;

	// start, direction and trigger select flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_ff  <= 5'h00;
			updn_ff   <= 5'h00;
			trgsel_ff <= 5'h00;
		end else if (wr_en && sel_i[0]) begin
			if (adr_i[7:2] == `TMA_START_OFS >> 2) begin
				start_ff <= dat_i[4:0];
			end else if (adr_i[7:2] == `TMA_UPDN_OFS >> 2) begin
				updn_ff <= dat_i[4:0];
			end else if (adr_i[7:2] == `TMA_TRGSEL_OFS >> 2) begin
				trgsel_ff <= dat_i[4:0];
			end
		end
	end

	// one-shot start is a self-clearing strobe, reads as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ost_ff <= 5'h00;
		end else if (wr_en && sel_i[0] &&
			adr_i[7:2] == `TMA_OSTART_OFS >> 2) begin
			ost_ff <= dat_i[4:0];
		end else begin
			ost_ff <= 5'h00;
		end
	end

	// ********************************************************
	// input synchronisers and prescaler
	// ********************************************************

	logic [4:0] trg_s1, trg_s2, trg_s3;
	logic [1:0] pin_s1, pin_s2;
	logic       sub_s1, sub_s2, sub_s3;
	logic [4:0] trig_rise;

	// pins are asynchronous; second stage feeds logic, third edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trg_s1 <= 5'h00;
			trg_s2 <= 5'h00;
			trg_s3 <= 5'h00;
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end else begin
			trg_s1 <= trig_i;
			trg_s2 <= trg_s1;
			trg_s3 <= trg_s2;
			pin_s1 <= pulse_i;
			pin_s2 <= pin_s1;
			sub_s1 <= subclk_i;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end

	assign trig_rise = trg_s2 & ~trg_s3;

	logic [4:0] pre_ff;
	logic [4:0] subpre_ff;
	logic       tick8, tick32, ticksub;

	// shared prescalers; sub-clock divides on its rising edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_ff    <= 5'h00;
			subpre_ff <= 5'h00;
		end else begin
			pre_ff <= 5'(pre_ff + 5'h01);
			if (sub_s2 && !sub_s3) begin
				subpre_ff <= 5'(subpre_ff + 5'h01);
			end
		end
	end

	assign tick8   = (pre_ff & `TMA_PRE_MASK8) == `TMA_PRE_MASK8;
	assign tick32  = pre_ff == `TMA_PRE_TOP;
	assign ticksub = sub_s2 && !sub_s3 && subpre_ff == `TMA_PRE_TOP;

	// pin level per channel; only channels 2 and 3 have one
	logic [4:0] pin_lvl;
	assign pin_lvl = {1'b0, pin_s2, 2'h0};

	// ********************************************************
	// channels
	// ********************************************************

	logic [4:0]       evt_vec;
	logic [4:0]       pout_vec;
	logic [4:0]       poe_vec;
	logic [4:0][7:0]  mode_vec;
	logic [4:0][15:0] rdt_vec;

	genvar g;
	generate
		for (g = 0; g < `TMA_NCH; g++) begin : g_ch
			localparam int NB1 = (g + 4) % 5;
			localparam int NB2 = (g + 1) % 5;
			localparam logic HAS_PIN = (g == 2) || (g == 3);

			logic [7:0]  mode_ff;
			logic [15:0] cnt_ff;
			logic [15:0] rld_ff;
			logic        act_ff;
			logic        out_ff;
			logic        evt_ff;
			tma_mode_t   md;
			logic        tick, src_evt, up, trig, run;
			logic        wr_mode, wr_tmr, free, lim_hit, term;
			logic        nxt_act, nxt_evt;
			logic [15:0] wval;

			assign md = tma_mode_t'(mode_ff[1:0]);
			assign wr_mode = wr_en &&
				chan_hit(adr_i, `TMA_MODE_OFS, 3'(g));
			assign wr_tmr = wr_en &&
				chan_hit(adr_i, `TMA_TMR_OFS, 3'(g));
			assign wval = merge16(rld_ff, dat_i[15:0], sel_i[1:0]);
			assign free = mode_ff[`TMA_F_FREE];

			// prescaled count source for timer and one-shot
			always_comb begin
				case (tma_src_t'(mode_ff[`TMA_F_SRC_HI:`TMA_F_SRC_LO]))
					TMA_SRC_DIV1:  tick = 1'b1;
					TMA_SRC_DIV8:  tick = tick8;
					TMA_SRC_DIV32: tick = tick32;
					default:       tick = ticksub;
				endcase
			end

			// event source: b timer or either neighbour
			always_comb begin
				case (mode_ff[`TMA_F_SRC_HI:`TMA_F_SRC_LO])
					2'h0:    src_evt = tb2_ovf_i;
					2'h1:    src_evt = evt_vec[NB1];
					2'h2:    src_evt = evt_vec[NB2];
					default: src_evt = 1'b0;
				endcase
			end

			// direction from pin only where a pin exists
			assign up = (HAS_PIN && mode_ff[`TMA_F_DIRSRC]) ?
				pin_lvl[g] : updn_ff[g];
			assign trig = trgsel_ff[g] && trig_rise[g];
			assign lim_hit = up ? (cnt_ff == `TMA_CNT_MAX) :
				(cnt_ff == `TMA_CNT_ZERO);
			// zero is reached when the last period of n expires
			assign term = cnt_ff <= 16'h0001;
			assign run = (md == TMA_TIMER || md == TMA_EVENT) ?
				start_ff[g] : (md == TMA_ONESHOT && act_ff);

			// one-shot activity; clearing start aborts the shot
			always_comb begin
				nxt_act = act_ff;
				if (md != TMA_ONESHOT || !start_ff[g]) begin
					nxt_act = 1'b0;
				end else if (ost_ff[g] || trig) begin
					nxt_act = 1'b1;
				end else if (act_ff && tick && term) begin
					nxt_act = 1'b0;
				end
			end

			// wrap events that interrupt and may toggle the pin
			always_comb begin
				case (md)
					TMA_TIMER:   nxt_evt = start_ff[g] && tick &&
						cnt_ff == `TMA_CNT_ZERO;
					TMA_EVENT:   nxt_evt = start_ff[g] && src_evt &&
						lim_hit;
					TMA_ONESHOT: nxt_evt = act_ff && tick && term
						&& !(ost_ff[g] || trig);
					default:     nxt_evt = 1'b0;
				endcase
			end

			// mode register
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					mode_ff <= 8'h00;
				end else if (wr_mode && sel_i[0]) begin
					mode_ff <= dat_i[7:0];
				end
			end

			// reload register takes every write
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					rld_ff <= `TMA_CNT_ZERO;
				end else if (wr_tmr) begin
					rld_ff <= wval;
				end
			end

			// counter
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cnt_ff <= `TMA_CNT_ZERO;
				end else if (wr_tmr && !run) begin
					cnt_ff <= wval;
				end else begin
					case (md)
						TMA_TIMER: begin
							if (start_ff[g] && tick) begin
								cnt_ff <= (cnt_ff == `TMA_CNT_ZERO) ?
									rld_ff : 16'(cnt_ff - 16'h0001);
							end
						end
						TMA_EVENT: begin
							if (start_ff[g] && src_evt) begin
								if (lim_hit && !free) begin
									cnt_ff <= rld_ff;
								end else if (up) begin
									cnt_ff <= 16'(cnt_ff + 16'h0001);
								end else begin
									cnt_ff <= 16'(cnt_ff - 16'h0001);
								end
							end
						end
						TMA_ONESHOT: begin
							if (start_ff[g] && (ost_ff[g] || trig)) begin
								cnt_ff <= rld_ff;
							end else if (act_ff && tick) begin
								cnt_ff <= term ? rld_ff :
									16'(cnt_ff - 16'h0001);
							end
						end
						default: begin
							cnt_ff <= cnt_ff;
						end
					endcase
				end
			end

			// activity, event pulse and pulse level
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					act_ff <= 1'b0;
					evt_ff <= 1'b0;
					out_ff <= 1'b0;
				end else begin
					act_ff <= nxt_act;
					evt_ff <= nxt_evt;
					if (md == TMA_ONESHOT) begin
						out_ff <= nxt_act;
					end else if (nxt_evt) begin
						out_ff <= !out_ff;
					end
				end
			end

			assign evt_vec[g]  = evt_ff;
			assign pout_vec[g] = out_ff;
			// pin drives only as pulse output, never as direction input
			assign poe_vec[g]  = HAS_PIN && mode_ff[`TMA_F_POE] &&
				md != TMA_PWM &&
				!(md == TMA_EVENT && mode_ff[`TMA_F_DIRSRC]);
			assign mode_vec[g] = mode_ff;
			assign rdt_vec[g]  = (md == TMA_ONESHOT) ?
				`TMA_INDET_VAL : cnt_ff;
		end
	endgenerate

	assign irq_o      = evt_vec;
	assign pulse_o    = pout_vec[3:2];
	assign pulse_oe_o = poe_vec[3:2];

	// ********************************************************
	// read mux
	// ********************************************************

	// unmapped addresses read zero and still acknowledge
	always_comb begin
		nxt_dat = 32'h00000000;
		if (adr_i[7:2] == `TMA_START_OFS >> 2) begin
			nxt_dat = {27'h0000000, start_ff};
		end else if (adr_i[7:2] == `TMA_UPDN_OFS >> 2) begin
			nxt_dat = {27'h0000000, updn_ff};
		end else if (adr_i[7:2] == `TMA_TRGSEL_OFS >> 2) begin
			nxt_dat = {27'h0000000, trgsel_ff};
		end else begin
			for (int c = 0; c < `TMA_NCH; c++) begin
				if (chan_hit(adr_i, `TMA_MODE_OFS, 3'(c))) begin
					nxt_dat = {24'h000000, mode_vec[c]};
				end else if (chan_hit(adr_i, `TMA_TMR_OFS, 3'(c))) begin
					nxt_dat = {16'h0000, rdt_vec[c]};
				end
			end
		end
	end

	// read data captured as ack rises
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_ff <= 32'h00000000;
		end else if (req && !ack_ff) begin
			dat_ff <= nxt_dat;
		end
	end

endmodule

/* File: tb/tma_timer_chk.sv */
// Purpose: port-level checks of the timer block
// Assumes: sees only the top ports
// Notes:   shadows start flags and pin-channel mode bits
`timescale 1ns/1ps
module tma_timer_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [1:0]  pulse_oe_o,
	input wire logic [4:0]  irq_o
);
	// ****
	// shadow registers
	// ****
	logic [4:0] start_ff;
	logic [4:0] m2_ff;
	logic [4:0] m3_ff;
	logic       wr_w;
	logic       req_w;
	assign wr_w = cyc_i && stb_i && we_i && ack_o && sel_i[0];
	assign req_w = cyc_i && stb_i && !ack_o;
	// writes land on the edge where ack is high, as in the design
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_ff <= 5'h00;
			m2_ff    <= 5'h00;
			m3_ff    <= 5'h00;
		end else if (wr_w) begin
			if (adr_i[7:2] == 6'h0A) start_ff <= dat_i[4:0];
			if (adr_i[7:2] == 6'h04) m2_ff <= dat_i[4:0];
			if (adr_i[7:2] == 6'h06) m3_ff <= dat_i[4:0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****
	// assertions
	// ****
	property p_ack_lat; req_w |=> ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat)
		else $error("ack late");
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack too long");
	property p_ack_cause; $rose(ack_o) |-> $past(req_w); endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_dat_hold; !req_w |=> $stable(dat_o); endproperty
	a_dat_hold: assert property (p_dat_hold)
		else $error("read data moved");
	property p_rd_zero;
		req_w && !we_i && (adr_i[7:2] == 6'h0C || adr_i >= 8'h38)
		|=> dat_o == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("nonzero read");
	// a stopped channel raises no request more than two cycles after its start flag clears
	property p_irq_start;
		(irq_o & ~($past(start_ff) | $past(start_ff, 2))) == 5'h00;
	endproperty
	a_irq_start: assert property (p_irq_start)
		else $error("irq while stopped");
	property p_oe2;
		pulse_oe_o[0] |-> m2_ff[2] && !(m2_ff[1:0] == 2'h1 && m2_ff[4]);
	endproperty
	a_oe2: assert property (p_oe2)
		else $error("ch2 pin enable");
	property p_oe3;
		pulse_oe_o[1] |-> m3_ff[2] && !(m3_ff[1:0] == 2'h1 && m3_ff[4]);
	endproperty
	a_oe3: assert property (p_oe3)
		else $error("ch3 pin enable");
endmodule

bind tma_timer tma_timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.pulse_oe_o(pulse_oe_o), .irq_o(irq_o));

/* File: tb/test_tma_timer.sv */
// Purpose: directed bench of the timer block
// Assumes: one-cycle Wishbone answer
// Notes:   sub-clock free-runs at a quarter of the clock rate
`timescale 1ns/1ps
module test_tma_timer;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, tb2_ovf_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic        ack_o, p, sub;
	logic [1:0]  pin;
	logic [4:0]  trig_i, irq_o;
	logic [1:0]  pulse_o, pulse_oe_o;
	int          n_errors, n_tests, cyc_cnt, c, s, s0;
	int          nirq [5];

	tma_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.subclk_i(sub), .tb2_ovf_i(tb2_ovf_i), .trig_i(trig_i),
		.pulse_i(pin), .pulse_o(pulse_o), .pulse_oe_o(pulse_oe_o),
		.irq_o(irq_o));

	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	// irq tally and hang guard
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		sub <= cyc_cnt[1];
		for (int i = 0; i < 5; i++)
			if (irq_o[i] === 1'h1) nirq[i] <= nirq[i] + 1;
		if (cyc_cnt == 20000) begin
			n_errors = n_errors + 1;
			conclude();
		end
	end
	// ****
	// tasks
	// ****
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'h1);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'h0, 32'h0);
		chk(rd, exp);
	endtask
	// cycles until the next irq of one channel
	task automatic wirq(input int ch);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (irq_o[ch] !== 1'h1 && c < 300);
	endtask
	task automatic ev(input int k);
		repeat (k) begin
			@(posedge clk_i);
			tb2_ovf_i <= 1'h1;
			@(posedge clk_i);
			tb2_ovf_i <= 1'h0;
		end
		repeat (4) @(posedge clk_i);
	endtask
	task automatic conclude();
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		{rst_i, cyc_i, stb_i, we_i, tb2_ovf_i} = 5'h10;
		adr_i = 8'h00;
		sel_i = 4'h3;
		dat_i = 32'h0;
		trig_i = 5'h00;
		pin = 2'h0;
		sub = 1'h0;
		{n_errors, n_tests, cyc_cnt} = '0;
		nirq = '{5{0}};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		// timer mode, divide by one
		wb(8'h04, 1'h1, 32'h5);
		rdc(8'h04, 32'h5);
		wb(8'h28, 1'h1, 32'h1);
		wirq(0);
		wirq(0);
		chk(c, 6);
		wb(8'h04, 1'h1, 32'h2);
		wirq(0);
		wirq(0);
		wirq(0);
		chk(c, 3);
		wb(8'h28, 1'h1, 32'h0);
		// let an underflow launched at the stop edge drain first
		repeat (2) @(posedge clk_i);
		s = nirq[0];
		repeat (20) @(posedge clk_i);
		chk(nirq[0] - s, 0);
		// pin channel, divide by eight, toggling pin
		wb(8'h18, 1'h1, 32'h44);
		wb(8'h1C, 1'h1, 32'h0);
		wb(8'h28, 1'h1, 32'h8);
		chk(pulse_oe_o, 2'h2);
		wirq(3);
		p = pulse_o[1];
		wirq(3);
		chk(c, 8);
		chk(pulse_o[1], !p);
		// event counting from the b timer
		wb(8'h08, 1'h1, 32'h1);
		wb(8'h2C, 1'h1, 32'h2);
		wb(8'h0C, 1'h1, 32'hFFFD);
		wb(8'h28, 1'h1, 32'h2);
		s = nirq[1];
		ev(2);
		rdc(8'h0C, 32'hFFFF);
		chk(nirq[1] - s, 0);
		ev(1);
		chk(nirq[1] - s, 1);
		rdc(8'h0C, 32'hFFFD);
		wb(8'h08, 1'h1, 32'h9);
		ev(3);
		rdc(8'h0C, 32'h0);
		wb(8'h2C, 1'h1, 32'h0);
		ev(1);
		rdc(8'h0C, 32'hFFFF);
		chk(nirq[1] - s, 3);
		wb(8'h08, 1'h1, 32'h1);
		wb(8'h28, 1'h1, 32'h0);
		wb(8'h0C, 1'h1, 32'h1);
		wb(8'h28, 1'h1, 32'h2);
		s = nirq[1];
		ev(1);
		chk(nirq[1] - s, 0);
		ev(1);
		chk(nirq[1] - s, 1);
		rdc(8'h0C, 32'h1);
		// neighbour source: channel 0 drives channel 1
		wb(8'h08, 1'h1, 32'h41);
		s0 = nirq[0];
		s = nirq[1];
		wb(8'h28, 1'h1, 32'h3);
		repeat (60) @(posedge clk_i);
		wb(8'h28, 1'h1, 32'h2);
		repeat (6) @(posedge clk_i);
		chk(nirq[1] - s, (nirq[0] - s0) / 2);
		// one-shot on channel 4
		wb(8'h20, 1'h1, 32'h2);
		wb(8'h24, 1'h1, 32'h6);
		wb(8'h28, 1'h1, 32'h10);
		s = nirq[4];
		wb(8'h30, 1'h1, 32'h10);
		wirq(4);
		chk(c >= 6 && c <= 10, 1);
		rdc(8'h24, 32'h0);
		repeat (30) @(posedge clk_i);
		chk(nirq[4] - s, 1);
		wb(8'h30, 1'h1, 32'h10);
		wb(8'h30, 1'h1, 32'h10);
		wirq(4);
		chk(c >= 6 && c <= 10, 1);
		repeat (30) @(posedge clk_i);
		chk(nirq[4] - s, 2);
		wb(8'h34, 1'h1, 32'h10);
		@(posedge clk_i);
		trig_i <= 5'h10;
		wirq(4);
		chk(c <= 14, 1);
		trig_i <= 5'h00;
		wb(8'h30, 1'h1, 32'h10);
		wb(8'h28, 1'h1, 32'h0);
		s = nirq[4];
		repeat (30) @(posedge clk_i);
		chk(nirq[4] - s, 0);
		// channel 2 pin: drives as output, not as direction input
		wb(8'h10, 1'h1, 32'h5);
		@(posedge clk_i);
		chk(pulse_oe_o, 2'h3);
		pin <= 2'h1;
		wb(8'h10, 1'h1, 32'h15);
		wb(8'h14, 1'h1, 32'hFFFE);
		chk(pulse_oe_o, 2'h2);
		wb(8'h28, 1'h1, 32'h4);
		ev(1);
		rdc(8'h14, 32'hFFFF);
		// sub-clock and divide by 32 sources on channel 0
		wb(8'h28, 1'h1, 32'h0);
		wb(8'h00, 1'h1, 32'hC0);
		wb(8'h04, 1'h1, 32'h0);
		wb(8'h28, 1'h1, 32'h1);
		wirq(0);
		wirq(0);
		chk(c, 128);
		wb(8'h00, 1'h1, 32'h80);
		wirq(0);
		wirq(0);
		chk(c, 32);
		wb(8'h28, 1'h1, 32'h0);
		wb(8'h3C, 1'h1, 32'h1234);
		rdc(8'h3C, 32'h0);
		conclude();
	end
endmodule
